// File: adc_serial_pkg.sv
// Purpose: Shared constants and types for the two-input converter serial port
// Assumes: mclk at 200 MHz; serial clock supplied by the host
// Notes:   Timing counts are derived from times in their own unit
`default_nettype none
package adc_serial_pkg;
	localparam int RESULT_BITS = 12;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] LEAD_ONES = 5'h03;
	localparam logic [4:0] TAG_POS = 5'h04;
	localparam logic [4:0] LAST_POS = 5'h10;
	localparam logic [4:0] COUNT_SAT = 5'h11;
	localparam logic [4:0] HOLD_FALL_HOST = 5'h02;
	localparam logic [4:0] HOLD_FALL_INT = 5'h01;
	localparam int MCLK_PERIOD_NS = 5;
	localparam int SEL_HIGH_MIN_NS = 60;
	localparam int SEL_HIGH_MIN_CYCLES = (SEL_HIGH_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int CONV_CYCLES_DEFAULT = 64;
	localparam logic [RESULT_BITS-1:0] CODE_RESET = 12'h000;

	typedef enum logic [1:0]
	{
		ST_SHUT    = 2'b00,
		ST_TRACK   = 2'b01,
		ST_CONVERT = 2'b10,
		ST_DONE    = 2'b11
	} convState_t;

	typedef struct packed
	{
		logic shutdown;
		logic track;
		logic hold;
		logic channel;
	} frontEnd_t;
endpackage
`default_nettype wire

// File: sync_two_ff.sv
// Purpose: Two-flop level synchroniser, one per bit
// Assumes: Inputs are levels or toggles that stay put for several cycles
// Notes:   First stage feeds only the second stage
`default_nettype none
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Data
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage1  <= '0;
			syncOut <= '0;
		end
		else
		begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule
`default_nettype wire

// File: adc_serial_port.sv
// Purpose: Serial read-out and channel sequencing of a two-input 12-bit converter
// Assumes: Host drives select and serial clock; analog code arrives on mclk
// Notes:   Serial shift runs on the serial clock; sequencing runs on mclk
//
// Functional notes
// - Output changes only on serial clock fall, apart from the internal-mode end-of-conversion flag
// - Output three-stated while select is high
// - Select high means shutdown, low wakes
// - First conversion after reset uses input zero
// - Each select cycle flips the channel pointer
// - Channel tag precedes MSB in every word
// - Tracking starts at select falling edge
// - Hold at second fall host, first internal
// - Result delivered serially as twelve bits
// - Clock level at select fall picks mode
// - Three ones, tag, twelve bits, then zeros
// - Internal mode: output high at conversion end
// - Select rising aborts; stay high 60ns
`default_nettype none
module adc_serial_port #(
	parameter int CONV_CYCLES = adc_serial_pkg::CONV_CYCLES_DEFAULT
) (
	// System clock and reset
	input  wire logic                                  mclk,
	input  wire logic                                  reset_n,
	// Host serial pins
	input  wire logic                                  selectShutdown_n,
	input  wire logic                                  serialClk,
	output logic                                       serialOut,
	output logic                                       serialOutEn,
	// Analog front end, mclk domain
	input  wire logic [adc_serial_pkg::RESULT_BITS-1:0] analogCode,
	output var adc_serial_pkg::frontEnd_t              frontEnd,
	output logic                                       wakeReady
);
	localparam int CW = $clog2(CONV_CYCLES + 1);

	// Serial clock domain
	logic                                    internalMode;
	logic [adc_serial_pkg::CNT_W-1:0]        fallCount;
	logic [adc_serial_pkg::CNT_W-1:0]        next_fallCount;
	logic                                    dataBit;
	logic                                    holdToggle;
	logic                                    frameClear;

	// mclk domain
	logic [2:0]                              syncIn;
	logic [2:0]                              syncOut;
	logic                                    selHigh;
	logic                                    selHighPrev;
	logic                                    holdSync;
	logic                                    holdSyncPrev;
	logic                                    modeInternal;
	logic                                    holdEvent;
	logic                                    selRise;
	logic                                    selFall;
	adc_serial_pkg::convState_t              state;
	logic [CW-1:0]                           convCount;
	logic [adc_serial_pkg::RESULT_BITS-1:0]  heldCode;
	logic                                    channel;
	logic                                    endOfConv;
	logic [7:0]                              highCount;

	// Word layout for the bit that appears after a given falling edge
	function automatic logic wordBit(
		input logic [adc_serial_pkg::CNT_W-1:0]       pos,
		input logic                                   tag,
		input logic [adc_serial_pkg::RESULT_BITS-1:0] code
	);
		logic [adc_serial_pkg::CNT_W-1:0] idx;
		idx = 5'h00;
		if (pos == 5'h00)
		begin
			wordBit = 1'b0;
		end
		else if (pos <= adc_serial_pkg::LEAD_ONES)
		begin
			wordBit = 1'b1;
		end
		else if (pos == adc_serial_pkg::TAG_POS)
		begin
			wordBit = tag;
		end
		else if (pos <= adc_serial_pkg::LAST_POS)
		begin
			idx = adc_serial_pkg::LAST_POS - pos;
			wordBit = code[idx[3:0]];
		end
		else
		begin
			wordBit = 1'b0;
		end
	endfunction

	// Mode caught on the select edge itself, so no serial clock edge is needed
	always_ff @(negedge selectShutdown_n or negedge reset_n)
	begin
		if (!reset_n)
		begin
			internalMode <= 1'b0;
		end
		else
		begin
			internalMode <= serialClk;
		end
	end

	// The frame's own select level clears the shifter; the serial clock may stop
	assign frameClear = selectShutdown_n | ~reset_n;

	always_comb
	begin
		next_fallCount = fallCount;
		if (fallCount != adc_serial_pkg::COUNT_SAT)
		begin
			next_fallCount = fallCount + 5'h01;
		end
	end

	always_ff @(negedge serialClk or posedge frameClear)
	begin
		if (frameClear)
		begin
			fallCount <= 5'h00;
			dataBit   <= 1'b0;
		end
		else
		begin
			fallCount <= next_fallCount;
			dataBit   <= wordBit(next_fallCount, channel, heldCode);
		end
	end

	// Hold event leaves the serial domain as a toggle
	always_ff @(negedge serialClk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			holdToggle <= 1'b0;
		end
		else if (!selectShutdown_n &&
			((internalMode && next_fallCount == adc_serial_pkg::HOLD_FALL_INT && fallCount != next_fallCount) ||
			(!internalMode && next_fallCount == adc_serial_pkg::HOLD_FALL_HOST && fallCount != next_fallCount)))
		begin
			holdToggle <= ~holdToggle;
		end
	end

	// First bit in internal mode is the end-of-conversion flag, raised without a clock
	always_comb
	begin
		if (internalMode && fallCount == adc_serial_pkg::HOLD_FALL_INT)
		begin
			serialOut = endOfConv;
		end
		else
		begin
			serialOut = dataBit;
		end
	end

	assign serialOutEn = ~selectShutdown_n;

	// Select travels inverted so the synchroniser's reset value matches the idle-high pin; no false edge after reset
	assign syncIn = {~selectShutdown_n, holdToggle, internalMode};

	sync_two_ff #(
		.WIDTH (3)
	) u_sync (
		.clk     (mclk),
		.reset_n (reset_n),
		.asyncIn (syncIn),
		.syncOut (syncOut)
	);

	assign selHigh      = ~syncOut[2];
	assign holdSync     = syncOut[1];
	assign modeInternal = syncOut[0];

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			selHighPrev  <= 1'b1;
			holdSyncPrev <= 1'b0;
		end
		else
		begin
			selHighPrev  <= selHigh;
			holdSyncPrev <= holdSync;
		end
	end

	assign holdEvent = holdSync ^ holdSyncPrev;
	assign selRise   = selHigh & ~selHighPrev;
	assign selFall   = ~selHigh & selHighPrev;

	// Channel pointer advances once per select cycle, at its end
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			channel <= 1'b0;
		end
		else if (selRise)
		begin
			channel <= ~channel;
		end
	end

	// Sequencing: any select rise drops back to shutdown, aborting a conversion
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= adc_serial_pkg::ST_SHUT;
		end
		else if (selHigh)
		begin
			state <= adc_serial_pkg::ST_SHUT;
		end
		else
		begin
			unique case (state)
				adc_serial_pkg::ST_SHUT:
				begin
					if (selFall)
					begin
						state <= adc_serial_pkg::ST_TRACK;
					end
				end
				adc_serial_pkg::ST_TRACK:
				begin
					if (holdEvent)
					begin
						state <= modeInternal ? adc_serial_pkg::ST_CONVERT : adc_serial_pkg::ST_DONE;
					end
				end
				adc_serial_pkg::ST_CONVERT:
				begin
					if (convCount == CW'(CONV_CYCLES - 1))
					begin
						state <= adc_serial_pkg::ST_DONE;
					end
				end
				adc_serial_pkg::ST_DONE:
				begin
					state <= adc_serial_pkg::ST_DONE;
				end
			endcase
		end
	end

	// Internal oscillator stand-in; it stops once the conversion is done
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			convCount <= '0;
		end
		else if (state == adc_serial_pkg::ST_CONVERT)
		begin
			convCount <= convCount + CW'(1);
		end
		else
		begin
			convCount <= '0;
		end
	end

	// Code is held steady for the shifter, which reads it from the fifth fall on
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			heldCode <= adc_serial_pkg::CODE_RESET;
		end
		else if (state == adc_serial_pkg::ST_TRACK && holdEvent && !selHigh)
		begin
			heldCode <= analogCode;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			endOfConv <= 1'b0;
		end
		else
		begin
			endOfConv <= !selHigh && modeInternal &&
				state == adc_serial_pkg::ST_CONVERT && convCount == CW'(CONV_CYCLES - 1);
			if (state == adc_serial_pkg::ST_DONE && !selHigh && modeInternal)
			begin
				endOfConv <= 1'b1;
			end
		end
	end

	// Minimum high time before the next frame; software-free status only
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			highCount <= 8'h00;
		end
		else if (!selHigh)
		begin
			highCount <= 8'h00;
		end
		else if (highCount != 8'(adc_serial_pkg::SEL_HIGH_MIN_CYCLES))
		begin
			highCount <= highCount + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frontEnd <= '{shutdown: 1'b1, track: 1'b0, hold: 1'b0, channel: 1'b0};
		end
		else
		begin
			frontEnd.shutdown <= selHigh;
			frontEnd.track    <= !selHigh && state == adc_serial_pkg::ST_TRACK;
			frontEnd.hold     <= !selHigh && (state == adc_serial_pkg::ST_CONVERT || state == adc_serial_pkg::ST_DONE);
			frontEnd.channel  <= channel;
		end
	end

	assign wakeReady = selHigh && highCount == 8'(adc_serial_pkg::SEL_HIGH_MIN_CYCLES);
endmodule
`default_nettype wire

// File: adc_serial_port_end.sv
// Purpose: Closing unit of the port's source list; holds no logic
// Assumes: Read after the other port files
// Notes:   Leaves the default net type as it found it
`default_nettype none
`default_nettype wire

// File: adc_serial_port_chk.sv
// Purpose: Pin checks of the converter serial port
// Assumes: Host holds the serial clock low while waiting for conversion
// Notes:   Sampled on mclk, so pin edges are seen a few cycles late
`default_nettype none
module adc_serial_port_chk #(
	parameter int CONV_CYCLES = 64
) (
	// System
	input  wire logic                      mclk,
	input  wire logic                      reset_n,
	// Host pins
	input  wire logic                      selectShutdown_n,
	input  wire logic                      serialClk,
	input  wire logic                      serialOut,
	input  wire logic                      serialOutEn,
	// Front end
	input  wire adc_serial_pkg::frontEnd_t frontEnd,
	input  wire logic                      wakeReady
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_hiZ; serialOutEn == !selectShutdown_n; endproperty
	a_hiZ:
	assert property (p_hiZ) else $error("output enable wrong");
	property p_shut; selectShutdown_n[*5] |-> frontEnd.shutdown && !frontEnd.track && !frontEnd.hold; endproperty
	a_shut:
	assert property (p_shut) else $error("no shutdown");
	property p_wake; (!selectShutdown_n)[*5] |-> !frontEnd.shutdown && !wakeReady; endproperty
	a_wake:
	assert property (p_wake) else $error("no wake");
	property p_track; $fell(selectShutdown_n) |-> ##[1:5] frontEnd.track; endproperty
	a_track:
	assert property (p_track) else $error("no tracking");
	property p_fall; serialOutEn && $past(serialOutEn) && $changed(serialOut) |-> !serialClk; endproperty
	a_fall:
	assert property (p_fall) else $error("output moved on high clock");
	property p_first; !$past(reset_n) |-> !frontEnd.channel; endproperty
	a_first:
	assert property (p_first) else $error("channel after reset");
	property p_flip; $rose(selectShutdown_n) |-> ##[1:6] $changed(frontEnd.channel); endproperty
	a_flip:
	assert property (p_flip) else $error("channel not advanced");
	property p_steady; $changed(frontEnd.channel) |-> selectShutdown_n; endproperty
	a_steady:
	assert property (p_steady) else $error("channel moved in frame");
	property p_settle; $rose(selectShutdown_n) |-> (!wakeReady)[*8]; endproperty
	a_settle:
	assert property (p_settle) else $error("ready too soon");
	property p_hold; $rose(frontEnd.hold) |-> !serialClk; endproperty
	a_hold:
	assert property (p_hold) else $error("hold off a falling edge");
	c_hold: cover property ($rose(frontEnd.hold));
	c_chan: cover property ($fell(frontEnd.channel));
	c_ready: cover property ($rose(wakeReady));
endmodule
bind adc_serial_port adc_serial_port_chk #(.CONV_CYCLES(CONV_CYCLES)) adc_serial_port_chk_i (.mclk, .reset_n,
	.selectShutdown_n, .serialClk, .serialOut, .serialOutEn, .frontEnd, .wakeReady);
`default_nettype wire

// File: adc_host_model.sv
// Purpose: Host serial master for the converter port
// Assumes: Serial clock of 64 ns that stands still between frames
// Notes:   Each bit is taken at the rise after its fall
`default_nettype none
module adc_host_model (
	// Clock for bounded waits
	input  wire logic mclk,
	// Serial pins
	output logic      selectShutdown_n,
	output logic      serialClk,
	input  wire logic dataLine
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		selectShutdown_n = 1'b1;
		serialClk = 1'b0;
	end
	// Zero clocks is a bare select toggle that skips a channel
	task automatic frame(input logic intMode, input int nClk, output logic [31:0] word, output logic busy);
		int k;
		word = '0;
		busy = 1'b0;
		serialClk = intMode;
		#64 selectShutdown_n = 1'b0;
		#64 serialClk = 1'b1;
		for (int n = 1; n <= nClk; n++)
		begin
			#32 serialClk = 1'b0;
			// Conversion has only just begun, so the line must still read low here
			if (intMode && n == 1)
			begin
				#8 busy = (dataLine === 1'b0);
				for (k = 0; k < 200 && dataLine !== 1'b1; k++)
				begin
					@(posedge mclk);
				end
			end
			#32 serialClk = 1'b1;
			word = {word[30:0], dataLine};
		end
		#32 selectShutdown_n = 1'b1;
		#32 serialClk = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: adc_serial_port_tb.sv
// Purpose: Self-checking bench of the converter serial port
// Assumes: Code held steady for each frame
// Notes:   Short conversion keeps internal-mode frames brief
`default_nettype none
module adc_serial_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic intMode; logic [4:0] nClk; logic [11:0] code; logic tag;} row_t;
	localparam row_t ROWS [5] = '{'{1'b0, 5'h10, 12'ha5c, 1'b0}, '{1'b0, 5'h10, 12'h3f0, 1'b1},
		'{1'b1, 5'h10, 12'h001, 1'b0}, '{1'b1, 5'h12, 12'hfff, 1'b1}, '{1'b0, 5'h11, 12'h800, 1'b0}};
	logic                      mclk = 1'b0;
	logic                      reset_n = 1'b0;
	logic                      selectShutdown_n;
	logic                      serialClk;
	logic                      serialOut;
	logic                      serialOutEn;
	logic [11:0]               analogCode = 12'h000;
	adc_serial_pkg::frontEnd_t frontEnd;
	logic                      wakeReady;
	logic                      lastOut = 1'b0;
	logic                      dataLine;
	logic [31:0]               word;
	logic                      busy;
	int                        n_mismatch = 0;
	int                        total_checks = 0;
	always #2.5 mclk = ~mclk;
	// Undriven line shows the inverse of its last value
	always @(posedge mclk)
		if (serialOutEn)
			lastOut <= serialOut;
	assign dataLine = serialOutEn ? serialOut : ~lastOut;
	adc_serial_port #(.CONV_CYCLES(8)) adc_serial_port_i (.mclk, .reset_n, .selectShutdown_n, .serialClk,
		.serialOut, .serialOutEn, .analogCode, .frontEnd, .wakeReady);
	adc_host_model adc_host_model_i (.mclk, .selectShutdown_n, .serialClk, .dataLine);
	task automatic results();
		if (n_mismatch == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(input logic intMode, input int nClk, input logic [11:0] code, input logic tag);
		logic [31:0] full;
		logic [31:0] got;
		full = {16'h0, 3'b111, tag, code};
		@(posedge mclk);
		#1 analogCode = code;
		adc_host_model_i.frame(intMode, nClk, got, busy);
		check(got, nClk >= 16 ? full << (nClk - 16) : full >> (16 - nClk));
		if (intMode)
		begin
			check(32'(busy), 32'h1);
		end
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge mclk);
		check(32'(serialOutEn), 32'h0);
		check(32'(frontEnd), 32'h8);
		for (int i = 0; i < 5; i++)
			run(ROWS[i].intMode, ROWS[i].nClk, ROWS[i].code, ROWS[i].tag);
		// Aborted frame still uses up its channel
		run(1'b0, 3, 12'h000, 1'b1);
		run(1'b0, 16, 12'h123, 1'b0);
		adc_host_model_i.frame(1'b0, 0, word, busy);
		run(1'b0, 16, 12'h456, 1'b0);
		repeat (20) @(posedge mclk);
		check(32'(wakeReady), 32'h1);
		#1 reset_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1 check(32'(frontEnd), 32'h8);
		run(1'b0, 16, 12'h7e1, 1'b0);
		results();
	end
	initial
	begin
		#100000;
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
